// file: serial_led_matrix_loader_pkg.sv
// Constants and carrier types for the serial LED matrix loader
package serial_led_matrix_loader_pkg;

  // Pixel chain and control word geometry
  localparam int DOT_BITS = 160;
  localparam int CTRL_BITS = 7;
  localparam int CTRL_SHIFT_BITS = 8;
  localparam int CTRL_WORD_SEL_POS = 7;
  localparam int SLEEP_N_POS = 6;
  localparam int DRIVE_LSB = 0;
  localparam int DRIVE_BITS = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_CTRL0 = 8'h04;
  localparam logic [7:0] OFS_CTRL1 = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_DOT_SEL = 8'h10;
  localparam logic [7:0] OFS_DOT_DATA = 8'h14;

  // Status bit positions
  localparam int ST_TARGET_POS = 0;
  localparam int ST_GATE_POS = 1;
  localparam int ST_SLEEP_POS = 2;
  localparam int ST_BLANK_POS = 3;
  localparam int ST_OSCSEL_POS = 4;

  // Reset values, timebase and pixel word count
  localparam logic [15:0] OSC_HALF_RST = 16'h0271;
  localparam logic [2:0] DOT_SEL_RST = 3'h0;
  localparam int DOT_WORDS = 5;

  // Pin samples, synchronised together
  typedef struct packed {
    logic serClk;
    logic serData;
    logic writeGateN;
    logic targetChoose;
    logic resetN;
    logic oscSelect;
    logic timebaseIn;
    logic displayOff;
  } pins_t;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

endpackage : serial_led_matrix_loader_pkg

// file: serial_led_matrix_loader.sv
// Serial pixel and control word loader with APB status window
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RQ1: Reset input low clears every control register bit to zero.
// RQ2: Reset input leaves the pixel shift chain and latched pixels untouched.
// RQ3: Reset input is active low; high means normal operation.
// RQ4: Serial data bit is sampled on each rising serial clock edge.
// RQ5: Clock edges shift data only while the write gate is low.
// RQ6: Bit leaving the selected chain appears on the serial output pin.
// RQ7: Select low routes data to pixel chain, high to control chain.
// RQ8: Select level is captured when the write gate falls and held.
// RQ9: Host keeps the write gate low for the whole write.
// RQ10: Gate rising with clock low transfers data to drivers or control.
// RQ11: Oscillator select low picks external timebase, high internal.
// RQ12: Timebase pin drives internal oscillator out, else serves as input.
// RQ13: Blanking input high turns every LED off.
// RQ14: Host may modulate blanking for brightness; optional.
// RQ15: Sleep stops internal oscillator and reference current for drivers.
// RQ16: Control word 0 holds the maximum drive current setting.
// RQ17: Pixel chain is 160 bits, one bit per LED.
// RQ18: Two separate 7-bit control words are held.
// RQ19: Serial output can feed a second controller forming a 320-bit chain.
// RQ20: Each accepted edge shifts one place; oldest bit reaches serial output.
module serial_led_matrix_loader
  import serial_led_matrix_loader_pkg::*;
#(
  parameter int DOTS = DOT_BITS,
  parameter int OSC_CNT_BITS = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire apb_req_t apbReq,
  output apb_rsp_t apbRsp,
  input wire logic serClk,
  input wire logic serData,
  input wire logic writeGateN,
  input wire logic targetChoose,
  input wire logic resetN,
  input wire logic oscSelect,
  input wire logic timebasePinIn,
  output logic timebasePinOut,
  output logic timebasePinOe,
  input wire logic displayOffInput,
  output logic serOut,
  output logic [DOTS-1:0] ledDrive,
  output logic [DRIVE_BITS-1:0] driveLevel,
  output logic driveRefOn,
  output logic timebaseTick
);

  typedef struct packed {
    pins_t sync1;
    pins_t sync2;
    logic clkPrev;
    logic gatePrev;
    logic extPrev;
    logic target;
    logic [DOTS-1:0] dotShift;
    logic [DOTS-1:0] dotLatch;
    logic [CTRL_SHIFT_BITS-1:0] ctrlShift;
    logic [CTRL_BITS-1:0] ctrl0;
    logic [CTRL_BITS-1:0] ctrl1;
    logic [OSC_CNT_BITS-1:0] oscCnt;
    logic [OSC_CNT_BITS-1:0] oscHalf;
    logic tbOut;
    logic tbOe;
    logic tick;
    logic [DOTS-1:0] led;
    logic [DRIVE_BITS-1:0] drive;
    logic refOn;
    logic serOut;
    logic [2:0] dotSel;
    apb_rsp_t rsp;
  } state_t;

  state_t q;
  state_t d;

  pins_t pinNow;
  assign pinNow = '{
    serClk: serClk,
    serData: serData,
    writeGateN: writeGateN,
    targetChoose: targetChoose,
    resetN: resetN,
    oscSelect: oscSelect,
    timebaseIn: timebasePinIn,
    displayOff: displayOffInput
  };

  logic clkRise;
  logic gateFall;
  logic gateRise;
  logic shiftEn;
  logic asleep;
  logic blanked;
  logic intTick;
  logic extTick;
  logic apbSetup;
  logic apbWrite;
  logic [31:0] dotWord;

  always_comb begin
    dotWord = 32'h0000_0000;
    for (int w = 0; w < DOT_WORDS; w++) begin
      if ((32 * w + 31 < DOTS) && (int'(q.dotSel) == w)) begin
        dotWord = q.dotLatch[32 * w +: 32];
      end
    end
  end

  always_comb begin
    d = q;
    // Two flops on every pin before use
    d.sync1 = pinNow;
    d.sync2 = q.sync1;
    d.clkPrev = q.sync2.serClk;
    d.gatePrev = q.sync2.writeGateN;
    d.extPrev = q.sync2.timebaseIn;

    clkRise = q.sync2.serClk && !q.clkPrev; // RQ4
    gateFall = !q.sync2.writeGateN && q.gatePrev;
    gateRise = q.sync2.writeGateN && !q.gatePrev;
    shiftEn = clkRise && !q.sync2.writeGateN; // RQ5 RQ9

    if (gateFall) begin
      d.target = q.sync2.targetChoose; // RQ8
    end

    if (shiftEn) begin
      if (!q.target) begin
        d.dotShift = {q.dotShift[DOTS-2:0], q.sync2.serData}; // RQ7 RQ20 RQ17
      end else begin
        d.ctrlShift = {q.ctrlShift[CTRL_SHIFT_BITS-2:0],
                       q.sync2.serData}; // RQ7 RQ20
      end
    end

    // Oldest bit of the selected chain, cascades to the next part
    if (d.target) begin
      d.serOut = d.ctrlShift[CTRL_SHIFT_BITS-1]; // RQ6
    end else begin
      d.serOut = d.dotShift[DOTS-1]; // RQ6 RQ19
    end

    // Transfer only when the gate rises with the serial clock low
    if (gateRise && !q.sync2.serClk) begin // RQ10
      if (!q.target) begin
        d.dotLatch = q.dotShift;
      end else if (q.ctrlShift[CTRL_WORD_SEL_POS]) begin
        d.ctrl1 = q.ctrlShift[CTRL_BITS-1:0]; // RQ18
      end else begin
        d.ctrl0 = q.ctrlShift[CTRL_BITS-1:0]; // RQ18
      end
    end

    asleep = !q.ctrl0[SLEEP_N_POS];
    blanked = q.sync2.displayOff;

    // Internal oscillator, halted in sleep
    intTick = 1'b0;
    if (asleep) begin // RQ15
      d.oscCnt = '0;
    end else if (q.oscCnt >= q.oscHalf) begin
      d.oscCnt = '0;
      d.tbOut = !q.tbOut;
      intTick = !q.tbOut;
    end else begin
      d.oscCnt = q.oscCnt + OSC_CNT_BITS'(1);
    end
    extTick = q.sync2.timebaseIn && !q.extPrev;
    d.tbOe = q.sync2.oscSelect; // RQ12
    d.tick = q.sync2.oscSelect ? intTick : extTick; // RQ11

    d.led = (blanked || asleep) ? '0 : d.dotLatch; // RQ13 RQ15
    d.drive = q.ctrl0[DRIVE_LSB +: DRIVE_BITS]; // RQ16
    d.refOn = !asleep; // RQ15

    // APB slave, answer in the first access cycle
    apbSetup = apbReq.psel && !apbReq.penable;
    apbWrite = apbReq.psel && apbReq.penable && apbReq.pwrite &&
               q.rsp.pready;
    d.rsp.pready = apbSetup;
    d.rsp.pslverr = 1'b0;
    d.rsp.prdata = 32'h0000_0000;
    if (apbSetup) begin
      case (apbReq.paddr)
        OFS_CONFIG: d.rsp.prdata = 32'(q.oscHalf);
        OFS_CTRL0: d.rsp.prdata = 32'(q.ctrl0);
        OFS_CTRL1: d.rsp.prdata = 32'(q.ctrl1);
        OFS_STATUS: begin
          d.rsp.prdata[ST_TARGET_POS] = q.target;
          d.rsp.prdata[ST_GATE_POS] = !q.sync2.writeGateN;
          d.rsp.prdata[ST_SLEEP_POS] = asleep;
          d.rsp.prdata[ST_BLANK_POS] = blanked;
          d.rsp.prdata[ST_OSCSEL_POS] = q.sync2.oscSelect;
        end
        OFS_DOT_SEL: d.rsp.prdata = 32'(q.dotSel);
        OFS_DOT_DATA: d.rsp.prdata = dotWord;
        default: d.rsp.pslverr = 1'b1;
      endcase
      if (apbReq.pwrite) begin
        d.rsp.prdata = 32'h0000_0000;
      end
      if (apbReq.pwrite && apbReq.paddr != OFS_CONFIG &&
          apbReq.paddr != OFS_DOT_SEL) begin
        d.rsp.pslverr = 1'b1;
      end
    end
    if (apbWrite) begin
      case (apbReq.paddr)
        OFS_CONFIG: d.oscHalf = apbReq.pwdata[OSC_CNT_BITS-1:0];
        OFS_DOT_SEL: d.dotSel = apbReq.pwdata[2:0];
        default: d.dotSel = q.dotSel;
      endcase
    end

    // Reset pin clears control state only
    if (!q.sync2.resetN) begin // RQ3
      d.ctrl0 = '0; // RQ1
      d.ctrl1 = '0; // RQ1
      d.ctrlShift = '0; // RQ1
    end

    if (rst) begin
      d = '0;
      d.sync1.writeGateN = 1'b1;
      d.sync2.writeGateN = 1'b1;
      d.sync1.resetN = 1'b1;
      d.sync2.resetN = 1'b1;
      d.gatePrev = 1'b1;
      d.oscHalf = OSC_CNT_BITS'(OSC_HALF_RST);
      d.dotSel = DOT_SEL_RST;
    end
  end

  always_ff @(posedge clock) begin
    q <= d;
  end

  assign apbRsp = q.rsp;
  assign timebasePinOut = q.tbOut;
  assign timebasePinOe = q.tbOe;
  assign serOut = q.serOut;
  assign ledDrive = q.led;
  assign driveLevel = q.drive;
  assign driveRefOn = q.refOn;
  assign timebaseTick = q.tick;

endmodule : serial_led_matrix_loader
`default_nettype wire

// file: serial_led_matrix_loader_assertions.sv
// Port-level checker for the serial LED matrix loader
`timescale 1ns/10ps
`default_nettype none
module serial_led_matrix_loader_assertions
  import serial_led_matrix_loader_pkg::*;
#(
  parameter int DOTS = DOT_BITS
) (
  input wire logic clock,
  input wire logic rst,
  input wire apb_req_t apbReq,
  input wire apb_rsp_t apbRsp,
  input wire logic oscSelect,
  input wire logic displayOffInput,
  input wire logic timebasePinOe,
  input wire logic [DOTS-1:0] ledDrive,
  input wire logic [DRIVE_BITS-1:0] driveLevel,
  input wire logic driveRefOn
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_blank_dark: assert property (
    displayOffInput [*4] |=> ledDrive == '0) else $error("lit while blank");
  a_sleep_dark: assert property (
    !driveRefOn [*2] |-> ledDrive == '0) else $error("lit while asleep");
  a_osc_drive: assert property (
    oscSelect [*4] |=> timebasePinOe) else $error("pin not driven");
  a_osc_input: assert property (
    !oscSelect [*4] |=> !timebasePinOe) else $error("pin driven");
  a_ready_next: assert property (
    apbReq.psel && !apbReq.penable |=> apbRsp.pready)
    else $error("no ready");
  a_ready_once: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready too long");
  a_bad_addr: assert property (
    apbReq.psel && !apbReq.penable && apbReq.paddr[7:5] != 3'h0
    |=> apbRsp.pslverr && apbRsp.prdata == '0) else $error("no error");
  a_reset_idle: assert property (
    $fell(rst) |-> !driveRefOn && driveLevel == '0 && !apbRsp.pready)
    else $error("not idle after reset");
endmodule : serial_led_matrix_loader_assertions
bind serial_led_matrix_loader serial_led_matrix_loader_assertions #(
  .DOTS(DOTS)) chk (.clock(clock), .rst(rst), .apbReq(apbReq),
  .apbRsp(apbRsp), .oscSelect(oscSelect), .displayOffInput(displayOffInput),
  .timebasePinOe(timebasePinOe), .ledDrive(ledDrive),
  .driveLevel(driveLevel), .driveRefOn(driveRefOn));
`default_nettype wire

// file: serial_host_model.sv
// Host controller driving the serial load pins
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  input wire logic clock,
  output logic serClk,
  output logic serData,
  output logic writeGateN,
  output logic targetChoose
);
  initial begin
    serClk = 1'b0;
    serData = 1'b0;
    writeGateN = 1'b1;
    targetChoose = 1'b0;
  end
  task wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_cyc
  // Clock idles low, four system cycles per half period
  task send(input logic sel, input logic [159:0] d, input int n,
    input logic endHigh);
    int i;
    @(posedge clock);
    targetChoose <= sel;
    wait_cyc(5);
    writeGateN <= 1'b0;
    wait_cyc(5);
    // Select flips mid-frame; the latched level must hold
    targetChoose <= ~sel;
    for (i = n - 1; i >= 0; i--) begin
      serData <= d[i];
      wait_cyc(4);
      serClk <= 1'b1;
      wait_cyc(4);
      if (i > 0 || !endHigh) begin
        serClk <= 1'b0;
      end
    end
    wait_cyc(5);
    writeGateN <= 1'b1;
    wait_cyc(5);
    serClk <= 1'b0;
    serData <= ~serData;
  endtask : send
endmodule : serial_host_model
`default_nettype wire

// file: tb_serial_led_matrix_loader.sv
// Self-checking bench for the serial LED matrix loader
`timescale 1ns/10ps
`default_nettype none
module tb_serial_led_matrix_loader;
  import serial_led_matrix_loader_pkg::*;
  localparam logic [159:0] PAT = {5{32'hA5C3_0F96}};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic resetN = 1'b1;
  logic oscSel = 1'b1;
  logic blank = 1'b0;
  logic [3:0] pinCnt = 4'h0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic sClk, sDat, gateN, tgt, pOut, pOe, sOut, refOn, tick, er;
  logic [DOT_BITS-1:0] leds;
  logic [3:0] level;
  logic [31:0] rd;
  int error_cnt = 0;
  int n_checks = 0;
  int nt;
  wire pin = pOe ? pOut : pinCnt[3];
  serial_led_matrix_loader uut (.clock(clock), .rst(rst), .apbReq(req),
    .apbRsp(rsp), .serClk(sClk), .serData(sDat), .writeGateN(gateN),
    .targetChoose(tgt), .resetN(resetN), .oscSelect(oscSel),
    .timebasePinIn(pin), .timebasePinOut(pOut), .timebasePinOe(pOe),
    .displayOffInput(blank), .serOut(sOut), .ledDrive(leds),
    .driveLevel(level), .driveRefOn(refOn), .timebaseTick(tick));
  serial_host_model host (.clock(clock), .serClk(sClk), .serData(sDat),
    .writeGateN(gateN), .targetChoose(tgt));
  initial forever #2 clock = ~clock;
  always @(posedge clock) pinCnt <= pinCnt + 4'h1;
  task check(input logic [159:0] got, input logic [159:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %0h want %0h", $time, got, exp);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clock);
    req.penable <= 1'b1;
    do @(posedge clock); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask : apb
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task ticks(input logic sel);
    oscSel <= sel;
    cyc(8);
    nt = 0;
    repeat (40) begin
      @(posedge clock);
      if (tick === 1'b1) nt++;
    end
  endtask : ticks
  task t_regs;
    apb(1'b0, OFS_CONFIG, 32'h0);
    check(rd, 32'(OSC_HALF_RST));
    apb(1'b1, OFS_CONFIG, 32'h0000_0002);
    check(er, 1'b0);
    apb(1'b0, OFS_CONFIG, 32'h0);
    check(rd, 32'h0000_0002);
    apb(1'b1, OFS_CTRL0, 32'h0000_007F);
    check(er, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    check(er, 1'b1);
  endtask : t_regs
  task t_ctrl;
    host.send(1'b1, 160'hC5, 8, 1'b0);
    cyc(10);
    check(sOut, 1'b1);
    host.send(1'b1, 160'h4A, 8, 1'b0);
    cyc(10);
    check(level, 4'hA);
    check(refOn, 1'b1);
    apb(1'b0, OFS_CTRL1, 32'h0);
    check(rd, 32'h0000_0045);
  endtask : t_ctrl
  task t_pixels;
    host.send(1'b0, PAT, DOT_BITS, 1'b0);
    cyc(10);
    check(leds, PAT);
    check(sOut, PAT[159]);
    apb(1'b1, OFS_DOT_SEL, 32'h0000_0004);
    apb(1'b0, OFS_DOT_DATA, 32'h0);
    check(rd, 32'hA5C3_0F96);
    host.send(1'b0, ~PAT, DOT_BITS, 1'b1);
    cyc(10);
    check(leds, PAT);
  endtask : t_pixels
  task t_blank;
    blank <= 1'b1;
    cyc(6);
    check(leds, 160'h0);
    blank <= 1'b0;
    cyc(6);
    check(leds, PAT);
    repeat (4) begin
      blank <= ~blank;
      cyc(6);
      check(leds, blank ? 160'h0 : PAT);
    end
  endtask : t_blank
  task t_osc;
    ticks(1'b1);
    check(nt != 0, 1'b1);
    check(pOe, 1'b1);
    ticks(1'b0);
    check(nt != 0, 1'b1);
    check(pOe, 1'b0);
  endtask : t_osc
  task t_reset_pin;
    resetN <= 1'b0;
    ticks(1'b1);
    check(nt, 0);
    check(level, 4'h0);
    check(refOn, 1'b0);
    check(leds, 160'h0);
    resetN <= 1'b1;
    host.send(1'b1, 160'h4A, 8, 1'b0);
    cyc(10);
    check(leds, PAT);
  endtask : t_reset_pin
  task complete_run;
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    cyc(12);
    rst <= 1'b0;
    cyc(1);
    t_regs;
    t_ctrl;
    t_pixels;
    t_blank;
    t_osc;
    t_reset_pin;
    complete_run;
  end
  initial begin
    #200000;
    error_cnt++;
    complete_run;
  end
endmodule : tb_serial_led_matrix_loader
`default_nettype wire
